// ---- qpf_core.sv ----
// qpf_core: four-phase generator, two-stage fetch/execute sequencer and pin roles.
// assumes pins pass two flip-flops here; decode/ALU supply the branch request.
//
// Summary of operation
// - The core clock is divided by four into non-overlapping phases one to four.
// - The program counter advances in phase one of every instruction cycle.
// - The fetched word is captured into the instruction register at the end of phase four.
// - The captured instruction is decoded and executed in phases two to four of the next cycle.
// - The operand is read in phase two and the destination written in phase four.
// - Fetch of the next instruction overlaps execution, one instruction per cycle.
// - A program counter change flushes the fetched word, so a branch takes two cycles.
// - In RC mode the oscillator output carries a cycle clock at a quarter of input rate.
// - The device stays in reset while master clear is low and resumes when it goes high.
// - Port A bit four can feed the timer clock, and as an output only pulls low.
// - A software enable turns on weak pull-ups on port B pins set as inputs.
// - Port B bit zero can be the external interrupt input, read through a Schmitt input.
// - Any change on port B bits four to seven raises an interrupt-on-change event.
// - In programming mode port B bit six is the programmer's clock and bit seven the data.
`default_nettype none
module qpf_core
  import qpf_pkg::*;
#(
  parameter int unsigned PC_WIDTH = PC_W
) (
  // clock and reset
  input  wire logic                sys_clk_i,
  input  wire logic                reset_i,
  input  wire logic                master_clear_n_i,
  // program memory
  output logic [PC_WIDTH-1:0]      program_counter_o,
  input  wire logic [INSTR_W-1:0]  prog_data_i,
  // branch from the execute stage
  input  wire logic                branch_i,
  input  wire logic [PC_WIDTH-1:0] branch_target_i,
  // pipeline status
  output qpf_phase_s               phase_o,
  output qpf_exec_s                exec_o,
  // oscillator output
  input  wire logic                rc_mode_i,
  output logic                     osc_out_o,
  // port a bit four
  input  wire logic                timer_clk_sel_i,
  input  wire logic                port_a_a_bit4_drive_low_i,
  input  wire logic                port_a_a_bit4_timer_clk_i,
  output logic                     port_a_a_bit4_timer_clk_o,
  output logic                     port_a_a_bit4_timer_clk_oe_n_o,
  output logic                     timer_ext_clock_o,
  // port b
  input  wire logic [7:0]          port_b_b_i,
  input  wire logic [7:0]          port_b_dir_in_i,
  input  wire logic                pullup_en_i,
  output logic [7:0]               port_b_pullup_o,
  input  wire logic                ext_irq_sel_i,
  output logic                     port_b_b_bit0_ext_irq_o,
  output logic                     schmitt_sel_o,
  output logic                     change_irq_o,
  // serial programming
  input  wire logic                prog_mode_i,
  output logic                     port_b_b_bit6_prog_clk_o,
  output logic                     port_b_b_bit7_prog_data_o
);

  // reset vector and bound checker are only as wide as the package address
  if (PC_WIDTH < 2 || PC_WIDTH > PC_W) begin : g_width_check
    $error("qpf_core: PC_WIDTH out of range");
  end

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] master_clear_n_sync_q;
  logic [1:0] ra4_sync_q;
  logic [7:0] pb_meta_q;
  logic [7:0] pb_sync_q;
  logic [7:0] pb_last_q;
  logic       core_rst;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      master_clear_n_sync_q <= 2'h0;
    end else begin
      master_clear_n_sync_q <= {master_clear_n_sync_q[0], master_clear_n_i};
    end
  end

  // core held while the synchronised master clear reads low
  assign core_rst = ~master_clear_n_sync_q[1];

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ra4_sync_q <= 2'h0;
      pb_meta_q  <= 8'h00;
      pb_sync_q  <= 8'h00;
    end else begin
      ra4_sync_q <= {ra4_sync_q[0], port_a_a_bit4_timer_clk_i};
      pb_meta_q  <= port_b_b_i;
      pb_sync_q  <= pb_meta_q;
    end
  end

  // ------------------------------------------------------------
  // phase generator
  // ------------------------------------------------------------
  qpf_phase_e phase_q;
  qpf_phase_e phase_d;

  always_comb begin
    case (phase_q)
      QPF_PH_ONE:   phase_d = QPF_PH_TWO;
      QPF_PH_TWO:   phase_d = QPF_PH_THREE;
      QPF_PH_THREE: phase_d = QPF_PH_FOUR;
      QPF_PH_FOUR:  phase_d = QPF_PH_ONE;
      default:      phase_d = QPF_PH_ONE;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_q <= QPF_PH_ONE;
    end else if (core_rst) begin
      phase_q <= QPF_PH_ONE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // one-hot decode from one register, so no two phases ever overlap
  always_comb begin
    phase_o.phase_one   = (phase_q == QPF_PH_ONE);
    phase_o.phase_two   = (phase_q == QPF_PH_TWO);
    phase_o.phase_three = (phase_q == QPF_PH_THREE);
    phase_o.phase_four  = (phase_q == QPF_PH_FOUR);
  end

  // ------------------------------------------------------------
  // fetch stage
  // ------------------------------------------------------------
  logic [PC_WIDTH-1:0] pc_q;
  logic [INSTR_W-1:0]  fetch_q;
  logic                fetch_valid_q;
  logic                flush_q;

  // branch request is sampled while the branching instruction executes
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pc_q    <= PC_RESET[PC_WIDTH-1:0];
      flush_q <= 1'b0;
    end else if (core_rst) begin
      pc_q    <= PC_RESET[PC_WIDTH-1:0];
      flush_q <= 1'b0;
    end else if (phase_q == QPF_PH_FOUR && branch_i && exec_o.valid) begin
      pc_q    <= branch_target_i;
      flush_q <= 1'b1;
    end else if (phase_q == QPF_PH_ONE) begin
      pc_q    <= pc_q + 1'b1;
      flush_q <= 1'b0;
    end
  end

  assign program_counter_o = pc_q;

  // word at the current address captured at the close of phase four
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fetch_q       <= INSTR_NOP;
      fetch_valid_q <= 1'b0;
    end else if (core_rst) begin
      fetch_q       <= INSTR_NOP;
      fetch_valid_q <= 1'b0;
    end else if (phase_q == QPF_PH_FOUR) begin
      fetch_q       <= prog_data_i;
      // a word fetched behind a branch is discarded
      fetch_valid_q <= ~(branch_i && exec_o.valid);
    end
  end

  // ------------------------------------------------------------
  // execute stage
  // ------------------------------------------------------------
  qpf_exec_s exec_q;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      exec_q <= '0;
    end else if (core_rst) begin
      exec_q <= '0;
    end else begin
      if (phase_q == QPF_PH_ONE) begin
        exec_q.instr <= fetch_q;
        exec_q.valid <= fetch_valid_q;
      end
      exec_q.operand_read <= (phase_d == QPF_PH_TWO);
      exec_q.dest_write   <= (phase_d == QPF_PH_FOUR);
    end
  end

  always_comb begin
    exec_o              = exec_q;
    exec_o.operand_read = exec_q.operand_read & exec_q.valid;
    exec_o.dest_write   = exec_q.dest_write & exec_q.valid;
  end

  // ------------------------------------------------------------
  // oscillator output and port a bit four
  // ------------------------------------------------------------
  logic cycle_clk_q;

  // high over phases three and four, one period per instruction cycle
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cycle_clk_q <= 1'b0;
    end else begin
      cycle_clk_q <= rc_mode_i && (phase_d == QPF_PH_THREE || phase_d == QPF_PH_FOUR);
    end
  end

  assign osc_out_o = cycle_clk_q;

  // open drain: data always low, enable active low only when pulling
  assign port_a_a_bit4_timer_clk_o      = 1'b0;
  assign port_a_a_bit4_timer_clk_oe_n_o = ~port_a_a_bit4_drive_low_i;
  assign timer_ext_clock_o           = timer_clk_sel_i & ra4_sync_q[1];

  // ------------------------------------------------------------
  // port b roles
  // ------------------------------------------------------------
  logic change_q;

  assign port_b_pullup_o = pullup_en_i ? port_b_dir_in_i : 8'h00;

  assign port_b_b_bit0_ext_irq_o = ext_irq_sel_i & pb_sync_q[0];
  // schmitt buffers steered by the selected role
  assign schmitt_sel_o        = ext_irq_sel_i | prog_mode_i;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pb_last_q <= 8'h00;
      change_q  <= 1'b0;
    end else begin
      pb_last_q <= pb_sync_q;
      change_q  <= |(pb_sync_q[7:4] ^ pb_last_q[7:4]);
    end
  end

  assign change_irq_o = change_q;

  // programmer drives the clock; the device only receives both lines
  assign port_b_b_bit6_prog_clk_o  = prog_mode_i & pb_sync_q[6];
  assign port_b_b_bit7_prog_data_o = prog_mode_i & pb_sync_q[7];

endmodule
`default_nettype wire

// ---- qpf_core_properties.sv ----
// qpf_props: port timing checks for qpf_core.
// assumes one clock domain; bound into every qpf_core.
`default_nettype none
module qpf_props
  import qpf_pkg::*;
(
  // watched ports
  input wire logic            sys_clk_i,
  input wire logic            reset_i,
  input wire logic            master_clear_n_i,
  input wire logic [PC_W-1:0] program_counter_o,
  input wire logic            branch_i,
  input wire logic [PC_W-1:0] branch_target_i,
  input wire qpf_phase_s      phase_o,
  input wire qpf_exec_s       exec_o,
  input wire logic            rc_mode_i,
  input wire logic            osc_out_o,
  input wire logic            port_a_a_bit4_timer_clk_o,
  input wire logic [7:0]      port_b_b_i,
  input wire logic            change_irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_i); endclocking
  // master clear low holds the core, so nothing runs
  default disable iff (reset_i || !master_clear_n_i);
  sequence s_tail;
    phase_o.phase_three ##1 phase_o.phase_four ##1 phase_o.phase_one;
  endsequence
  sequence s_access;
    exec_o.operand_read ##1 !exec_o.operand_read ##1 exec_o.dest_write;
  endsequence
  AST_ONE_HOT: assert property ($onehot(phase_o))
    else $error("phases not one-hot");
  AST_ORDER: assert property (phase_o.phase_two |=> s_tail)
    else $error("phase order");
  AST_PC_STEP: assert property ($rose(phase_o.phase_two) |->
    program_counter_o == $past(program_counter_o) + 1'b1) else $error("pc step");
  AST_PC_HOLD: assert property (phase_o.phase_two || phase_o.phase_three |=>
    $stable(program_counter_o)) else $error("pc moved");
  AST_ACCESS: assert property ($rose(phase_o.phase_two) && exec_o.valid |-> s_access)
    else $error("access timing");
  AST_EXEC_HOLD: assert property (!phase_o.phase_one |=>
    $stable({exec_o.valid, exec_o.instr})) else $error("exec changed");
  AST_FLUSH: assert property (phase_o.phase_four && exec_o.valid && branch_i |=>
    program_counter_o == $past(branch_target_i) ##1 !exec_o.valid [*4]) else $error("flush");
  AST_OSC: assert property (osc_out_o == ($past(rc_mode_i) &&
    (phase_o.phase_three || phase_o.phase_four))) else $error("cycle clock");
  AST_OPEN_DRAIN: assert property (!port_a_a_bit4_timer_clk_o)
    else $error("pin driven high");
  AST_CHANGE: assert property (port_b_b_i[7:4] != $past(port_b_b_i[7:4]) |->
    ##[1:4] change_irq_o) else $error("no change event");
endmodule
bind qpf_core qpf_props u_props (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
  .master_clear_n_i(master_clear_n_i), .program_counter_o(program_counter_o),
  .branch_i(branch_i), .branch_target_i(branch_target_i), .phase_o(phase_o),
  .exec_o(exec_o), .rc_mode_i(rc_mode_i), .osc_out_o(osc_out_o),
  .port_a_a_bit4_timer_clk_o(port_a_a_bit4_timer_clk_o), .port_b_b_i(port_b_b_i),
  .change_irq_o(change_irq_o));
`default_nettype wire

// ---- qpf_core_tb_top.sv ----
// qpf_core_tb_top: qpf_core against a cycle model of the pipeline.
// assumes qpf_mem_model answers fetches; all other pins are driven here.
`default_nettype none
module qpf_core_tb_top
  import qpf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk_i = 1'b0, reset_i = 1'b1, master_clear_n_n = 1'b0, br = 1'b0, rc = 1'b0;
  logic        tsel = 1'b0, dlow = 1'b0, ra4 = 1'b0, pue = 1'b0, isel = 1'b0, pmode = 1'b0;
  logic        osc, a4o, a4oe, tclk, eirq, smt, chg, pclk, pdat7, ra4w, fv, xv, rcq;
  logic [12:0] tgt = 13'h0000, pc;
  logic [13:0] pdat;
  logic [7:0]  pb = 8'h00, pdir = 8'h00, pbo, pull;
  logic [1:0]  mq;
  qpf_phase_s  ph_o;
  qpf_exec_s   ex_o;
  int          error_cnt = 0, checked = 0, cyc = 0, ph, mpc, fa, xa, k, pulses;
  // open drain with pull-up: low whenever the core pulls
  assign ra4w = (a4oe === 1'b0) ? 1'b0 : ra4;
  qpf_mem_model u_mem (.addr_i(pc), .data_o(pdat));
  qpf_core DUT (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .master_clear_n_i(master_clear_n_n),
    .program_counter_o(pc), .prog_data_i(pdat), .branch_i(br), .branch_target_i(tgt),
    .phase_o(ph_o), .exec_o(ex_o), .rc_mode_i(rc), .osc_out_o(osc),
    .timer_clk_sel_i(tsel), .port_a_a_bit4_drive_low_i(dlow), .port_a_a_bit4_timer_clk_i(ra4w),
    .port_a_a_bit4_timer_clk_o(a4o), .port_a_a_bit4_timer_clk_oe_n_o(a4oe),
    .timer_ext_clock_o(tclk), .port_b_b_i(pb), .port_b_dir_in_i(pdir), .pullup_en_i(pue),
    .port_b_pullup_o(pull), .ext_irq_sel_i(isel), .port_b_b_bit0_ext_irq_o(eirq),
    .schmitt_sel_o(smt), .change_irq_o(chg), .prog_mode_i(pmode),
    .port_b_b_bit6_prog_clk_o(pclk), .port_b_b_bit7_prog_data_o(pdat7));
  initial forever #50 sys_clk_i = ~sys_clk_i;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------
  // cycle model
  // ----------------------------------------
  always @(posedge sys_clk_i or posedge reset_i) begin
    mq <= reset_i ? 2'b00 : {mq[0], master_clear_n_n};
    rcq <= rc;
    if (reset_i || !mq[1]) begin
      ph <= 0;
      mpc <= 0;
      fv <= 1'b0;
      xv <= 1'b0;
    end else begin
      ph <= (ph + 1) % 4;
      if (ph == 0) begin
        mpc <= mpc + 1;
        xv <= fv;
        xa <= fa;
      end
      if (ph == 3) begin
        fa <= mpc;
        fv <= !(br && xv);
        if (br && xv) mpc <= tgt;
      end
    end
  end
  always @(negedge sys_clk_i) begin
    if (!reset_i) begin
      chk(ph_o, 4'b1000 >> ph);
      chk(pc, mpc);
      chk(ex_o.valid, xv);
      if (xv) chk(ex_o.instr, {1'b1, xa[12:0]} ^ 14'h15A5);
      chk({ex_o.operand_read, ex_o.dest_write}, {xv && ph == 1, xv && ph == 3});
      chk(osc, rcq && ph >= 2);
    end
  end
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(91453));
    repeat (4) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    master_clear_n_n <= 1'b1;
    repeat (40) @(posedge sys_clk_i);
    $display("straight run done");
    // branch raised in a random phase; only phase four with valid counts
    for (int i = 0; i < 60; i++) begin
      k = $urandom % 4;
      do @(negedge sys_clk_i); while (ph != (k + 3) % 4);
      @(posedge sys_clk_i);
      br <= 1'b1;
      tgt <= 13'($urandom) & 13'h0FFF;
      rc <= 1'($urandom);
      @(posedge sys_clk_i);
      br <= 1'b0;
    end
    master_clear_n_n <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    master_clear_n_n <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    $display("branch and master clear done");
    for (int i = 0; i < 30; i++) begin
      @(posedge sys_clk_i);
      pbo = pb;
      {pb, pdir} <= 16'($urandom);
      {pue, isel, pmode, tsel, dlow, ra4} <= 6'($urandom);
      pulses = 0;
      repeat (6) begin
        @(negedge sys_clk_i);
        pulses += (chg === 1'b1);
      end
      chk(pulses, pb[7:4] != pbo[7:4]);
      chk(pull, pue ? pdir : 8'h00);
      chk({eirq, smt}, {isel & pb[0], isel | pmode});
      chk({pclk, pdat7}, {pmode & pb[6], pmode & pb[7]});
      chk({tclk, a4oe, a4o}, {tsel & ra4 & !dlow, !dlow, 1'b0});
    end
    $display("pin roles done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ---- qpf_mem_model.sv ----
// qpf_mem_model: program memory answering the fetch port.
// assumes the word follows the fetch address with no wait.
`default_nettype none
module qpf_mem_model
  import qpf_pkg::*;
(
  input  wire logic [PC_W-1:0]    addr_i,
  output logic      [INSTR_W-1:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // address folded into the word so a wrong fetch shows
  assign data_o = {1'b1, addr_i} ^ 14'h15A5;
endmodule
`default_nettype wire

// ---- qpf_pkg.sv ----
// qpf_pkg: constants and carrier types for the quad phase fetch/execute timing block.
// assumes a single core clock that stands in for the oscillator input.
`default_nettype none
package qpf_pkg;
  // ------------------------------------------------------------
  // widths and reset values
  // ------------------------------------------------------------
  localparam int unsigned PC_W      = 13;
  localparam int unsigned INSTR_W   = 14;
  localparam logic [12:0] PC_RESET  = 13'h0000;
  localparam logic [13:0] INSTR_NOP = 14'h0000;
  localparam int unsigned NUM_PHASE = 4;

  // ------------------------------------------------------------
  // phase encoding
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    QPF_PH_ONE   = 2'b00,
    QPF_PH_TWO   = 2'b01,
    QPF_PH_THREE = 2'b10,
    QPF_PH_FOUR  = 2'b11
  } qpf_phase_e;

  // one-hot phase strobes
  typedef struct packed {
    logic phase_one;
    logic phase_two;
    logic phase_three;
    logic phase_four;
  } qpf_phase_s;

  // execute-stage strobes toward the data path
  typedef struct packed {
    logic       valid;
    logic       operand_read;
    logic       dest_write;
    logic [13:0] instr;
  } qpf_exec_s;
endpackage
`default_nettype wire
